// file: inc/mbx_consts.vh
`ifndef MBX_CONSTS_VH
`define MBX_CONSTS_VH
// Master / slave counts
`define MBX_NM 6
`define MBX_NS 5
// Split setting codes
`define MBX_SPLIT_INF 3'h0
`define MBX_SPLIT_SGL 3'h1
`define MBX_SPLIT_4 3'h2
`define MBX_SPLIT_8 3'h3
`define MBX_SPLIT_16 3'h4
`define MBX_SPLIT_RST 3'h2
// Default master kinds
`define MBX_DEF_NONE 2'h0
`define MBX_DEF_LAST 2'h1
`define MBX_DEF_FIXED 2'h2
// Arbitration kinds
`define MBX_ARB_RR 2'h0
`define MBX_ARB_PRIO 2'h1
// Slave configuration reset values
`define MBX_SLOT_RST 8'h10
// AHB burst codes
`define MBX_HB_SINGLE 3'h0
`define MBX_HB_INCR 3'h1
// AHB transfer types
`define MBX_HT_NSEQ 2'h2
`define MBX_HT_SEQ 2'h3
// Connectivity map: bit m*NS+s set when master m is wired to slave s
`define MBX_WIRED 30'h16BF_FFFF
`endif

// file: core/mbx_matrix_arb.v
`timescale 1ns/10ps
`include "mbx_consts.vh"
module mbx_matrix_arb (
    // Clock and reset
    input wire I_CORE_CLK,
    input wire I_SYS_RST,
    // Master requests, packed per master
    input wire [`MBX_NM*32-1:0] I_M_HADDR,
    input wire [`MBX_NM*2-1:0] I_M_HTRANS,
    input wire [`MBX_NM*3-1:0] I_M_HBURST,
    // Remap control, one bit per master
    input wire [`MBX_NM-1:0] I_REMAP_CONTROL,
    // Master config: split setting per master
    input wire [`MBX_NM*3-1:0] I_MASTER_CONFIG_SPLIT,
    // Slave config fields per slave
    input wire [`MBX_NS*8-1:0] I_SLAVE_CONFIG_SLOT,
    input wire [`MBX_NS*2-1:0] I_SLAVE_CONFIG_DEFKIND,
    input wire [`MBX_NS*4-1:0] I_SLAVE_CONFIG_DEFID,
    input wire [`MBX_NS*2-1:0] I_SLAVE_CONFIG_ARBKIND,
    // Slave priorities: 2 bits per master per slave
    input wire [`MBX_NS*`MBX_NM*2-1:0] I_SLAVE_PRIORITY,
    // Slave side ready
    input wire [`MBX_NS-1:0] I_S_HREADY,
    // Per-master stall, per-master selected slave
    output wire [`MBX_NM-1:0] O_M_HREADY,
    output wire [`MBX_NM*3-1:0] O_M_SLAVE_SEL,
    // Per-slave grant
    output wire [`MBX_NS-1:0] O_S_CONNECTED,
    output wire [`MBX_NS*3-1:0] O_S_MASTER
);
    localparam NM = `MBX_NM;
    localparam NS = `MBX_NS;
    localparam [NM*NS-1:0] WIRED = `MBX_WIRED;

    // ----------------------------------------------------
    // Overview
    // ----------------------------------------------------
    // Every master owns a decoder and a beat tracker. Each
    // slave owns an arbiter that picks one master to drive it.
    //
    // A master sees HREADY low while its slave is either
    // given to someone else or not yet connected. The
    // connection itself costs one cycle, except when the
    // slave was already parked on that master.
    //
    // Arbitration only happens at safe points so that a
    // burst is never cut in mid-beat: idle, single beats,
    // the predicted end of a burst, or an expired slot.
    //
    // Unwired paths are never requested. A master that
    // addresses one simply stalls; software must not do it.

    // ----------------------------------------------------
    // Per-master decoders and burst split tracking
    // ----------------------------------------------------
    wire [NM*NS-1:0] req; // bit m*NS+s
    wire [NM-1:0] eob; // predicted end of burst at this beat
    wire [NM-1:0] single;
    wire [NM*3-1:0] msel;
    genvar m, s;
    generate
        for (m = 0; m < NM; m = m + 1) begin : g_m
            wire [31:0] a = I_M_HADDR[m*32+:32];
            wire [1:0] tr = I_M_HTRANS[m*2+:2];
            wire [2:0] hb = I_M_HBURST[m*3+:3];
            wire [2:0] sp = I_MASTER_CONFIG_SPLIT[m*3+:3];
            reg [2:0] dsel;
            reg [4:0] beat_reg;
            reg [4:0] beat_next;
            reg [4:0] blen;
            // Own decoder; boot region remaps per master
            // The remap bit only moves the boot area, so the
            // other areas decode alike for every master.
            // The remap bit of one master never steers another.
            always @* begin
                case (a[31:28])
                    4'h0: dsel = I_REMAP_CONTROL[m] ? 3'h0 : 3'h2;
                    4'h2: dsel = 3'h0;
                    4'h3: dsel = 3'h1;
                    4'hF: dsel = 3'h4;
                    default: dsel = 3'h3;
                endcase
            end
            // Beat length of current burst
            // Wrapping and incrementing bursts of fixed size end
            // on their last beat. An undefined-length burst takes
            // its length from the split code of this master.
            // A length of zero means no predicted end at all.
            always @* begin
                case (hb)
                    3'h2, 3'h3: blen = 5'h04;
                    3'h4, 3'h5: blen = 5'h08;
                    3'h6, 3'h7: blen = 5'h10;
                    `MBX_HB_INCR: begin
                        case (sp)
                            `MBX_SPLIT_SGL: blen = 5'h01;
                            `MBX_SPLIT_4: blen = 5'h04;
                            `MBX_SPLIT_8: blen = 5'h08;
                            `MBX_SPLIT_16: blen = 5'h10;
                            default: blen = 5'h00;
                        endcase
                    end
                    default: blen = 5'h01;
                endcase
            end
            // Beat counter within current split
            // A new burst restarts at beat one; each accepted
            // sequential beat counts on and wraps at the split
            // length, which marks every boundary of that size.
            always @* begin
                beat_next = beat_reg;
                if (tr == `MBX_HT_NSEQ) begin
                    beat_next = 5'h01;
                end else if (tr == `MBX_HT_SEQ) begin
                    beat_next = (beat_reg == blen) ? 5'h01 : beat_reg + 5'h01;
                end
            end
            // Advance only on accepted beats, so wait states
            // never count as extra beats of the burst.
            always @(posedge I_CORE_CLK) begin
                if (I_SYS_RST) begin
                    beat_reg <= 5'h00;
                end else if (O_M_HREADY[m]) begin
                    beat_reg <= beat_next;
                end
            end
            // Predicted end of burst and single-beat flags
            assign eob[m] = (blen != 5'h00) && (beat_next == blen);
            assign single[m] = (hb == `MBX_HB_SINGLE) || (blen == 5'h01);
            assign msel[m*3+:3] = dsel;
            // Request to slave s only over a wired path
            for (s = 0; s < NS; s = s + 1) begin : g_rq
                assign req[m*NS+s] = tr[1] && (dsel == s) && WIRED[m*NS+s];
            end
        end
    endgenerate
    assign O_M_SLAVE_SEL = msel;

    // ----------------------------------------------------
    // One arbiter per slave
    // ----------------------------------------------------
    // Each arbiter holds whether its slave is connected, to
    // which master, the master served last (the rotation
    // point and the last-access default) and the slot budget.
    //
    // The slot budget is loaded when the owner starts a burst
    // and then runs down on every cycle. Only a sequential
    // beat may be broken by it; the first beat of a burst is
    // never cut, or a tiny budget would starve every burst.
    wire [NS*NM-1:0] gnt_vec;
    generate
        for (s = 0; s < NS; s = s + 1) begin : g_s
            wire [1:0] dk = I_SLAVE_CONFIG_DEFKIND[s*2+:2];
            wire [3:0] did = I_SLAVE_CONFIG_DEFID[s*4+:4];
            wire [1:0] ak = I_SLAVE_CONFIG_ARBKIND[s*2+:2];
            wire [7:0] slot = I_SLAVE_CONFIG_SLOT[s*8+:8];
            reg con_reg;
            reg [2:0] own_reg;
            reg [2:0] last_reg;
            reg [7:0] cnt_reg;
            reg [NM-1:0] rq;
            reg win_ok;
            reg [2:0] win;
            reg [1:0] bp;
            reg [2:0] k;
            integer i;
            wire own_act = rq[own_reg] && con_reg;
            wire [1:0] tr_o = I_M_HTRANS[own_reg*2+:2];
            // Arbitration window
            wire slot_out = (cnt_reg == 8'h00) && (tr_o == `MBX_HT_SEQ);
            wire can_arb = !own_act || single[own_reg] || eob[own_reg] || slot_out;
            // A fixed id that names an absent or unwired master
            // falls back to the no-default behaviour.
            wire fix_ok = (did < NM) && WIRED[did[2:0]*NS+s];
            // Request vector for this slave
            always @* begin
                for (i = 0; i < NM; i = i + 1) begin
                    rq[i] = req[i*NS+s];
                end
            end
            // Winner selection
            // Priority mode scans upwards and lets an equal value
            // replace the holder, so ties go to the highest number.
            // Round-robin scans downwards from the far end of the
            // ring, so the master nearest after the last owner
            // is the one that stays. Reserved kinds act as RR.
            always @* begin
                win_ok = 1'b0;
                win = 3'h0;
                bp = 2'h0;
                k = 3'h0;
                if (ak == `MBX_ARB_PRIO) begin
                    for (i = 0; i < NM; i = i + 1) begin
                        if (rq[i] && (!win_ok || I_SLAVE_PRIORITY[(s*NM+i)*2+:2] >= bp)) begin
                            win_ok = 1'b1;
                            win = i[2:0];
                            bp = I_SLAVE_PRIORITY[(s*NM+i)*2+:2];
                        end
                    end
                end else begin
                    // Rotate from the master after the last owner
                    for (i = NM - 1; i >= 0; i = i - 1) begin
                        k = (last_reg + 3'h1 + i[2:0] >= NM) ?
                            last_reg + 3'h1 + i[2:0] - 3'h6 : last_reg + 3'h1 + i[2:0];
                        if (rq[k]) begin
                            win_ok = 1'b1;
                            win = k;
                        end
                    end
                end
            end
            // Grant state, slot counter and default master
            // The grant moves only when the slave is ready, so a
            // beat in its wait states keeps its master. The slot
            // counter is not held by wait states: a slow slave is
            // exactly where the budget must keep running.
            always @(posedge I_CORE_CLK) begin
                if (I_SYS_RST) begin
                    con_reg <= 1'b0;
                    own_reg <= 3'h0;
                    last_reg <= 3'h5; // Rotation starts at master 0
                    cnt_reg <= 8'h00;
                end else begin
                    // Load at burst start, then one down per cycle
                    if (own_act && tr_o == `MBX_HT_NSEQ && I_S_HREADY[s]) begin
                        cnt_reg <= slot;
                    end else if (cnt_reg != 8'h00) begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                    if (I_S_HREADY[s] && can_arb) begin
                        // Any requester wins the slot, the owner too
                        if (win_ok) begin
                            con_reg <= 1'b1;
                            own_reg <= win;
                            last_reg <= win;
                        end else if (!own_act) begin
                            // Idle slave parks per policy
                            case (dk)
                                `MBX_DEF_LAST: begin
                                    con_reg <= con_reg;
                                end
                                `MBX_DEF_FIXED: begin
                                    con_reg <= fix_ok;
                                    own_reg <= fix_ok ? did[2:0] : own_reg;
                                end
                                default: begin
                                    con_reg <= 1'b0;
                                end
                            endcase
                        end
                    end
                end
            end
            // One-hot grant view of this slave for the masters
            for (m = 0; m < NM; m = m + 1) begin : g_g
                assign gnt_vec[s*NM+m] = con_reg && (own_reg == m);
            end
            assign O_S_CONNECTED[s] = con_reg;
            assign O_S_MASTER[s*3+:3] = own_reg;
        end
    endgenerate

    // ----------------------------------------------------
    // Master stall: low until the selected slave is granted
    // ----------------------------------------------------
    // Ready is combinational so that a parked master sees no
    // latency. An idle master always sees ready high, as an
    // AHB-Lite master expects between its transfers. A master
    // waiting for its connection sees it low for at least one cycle.
    generate
        for (m = 0; m < NM; m = m + 1) begin : g_rdy
            wire [2:0] sl = msel[m*3+:3];
            wire act = I_M_HTRANS[m*2+1];
            assign O_M_HREADY[m] = !act || (gnt_vec[sl*NM+m] && I_S_HREADY[sl]);
        end
    endgenerate
endmodule

// file: bench/mbx_asserts.sv
`timescale 1ns/10ps
`include "mbx_consts.vh"
module mbx_asserts (
    // Clock and reset
    input wire I_CORE_CLK,
    input wire I_SYS_RST,
    // Watched inputs
    input wire [`MBX_NM*32-1:0] I_M_HADDR,
    input wire [`MBX_NM*2-1:0] I_M_HTRANS,
    input wire [`MBX_NM-1:0] I_REMAP_CONTROL,
    input wire [`MBX_NS*2-1:0] I_SLAVE_CONFIG_DEFKIND,
    input wire [`MBX_NS*4-1:0] I_SLAVE_CONFIG_DEFID,
    // Watched outputs
    input wire [`MBX_NM-1:0] O_M_HREADY,
    input wire [`MBX_NM*3-1:0] O_M_SLAVE_SEL,
    input wire [`MBX_NS-1:0] O_S_CONNECTED,
    input wire [`MBX_NS*3-1:0] O_S_MASTER
);
    logic req3;
    wire [1:0] k3 = I_SLAVE_CONFIG_DEFKIND[7:6];
    wire [3:0] id3 = I_SLAVE_CONFIG_DEFID[15:12];
    wire [2:0] own3 = O_S_MASTER[11:9];
    wire c3 = O_S_CONNECTED[3];
    // Any master asking for slave 3
    always @* begin
        req3 = 1'b0;
        for (int m = 0; m < `MBX_NM; m++) begin
            if (I_M_HTRANS[m*2+1] && O_M_SLAVE_SEL[m*3+:3] == 3'h3) begin
                req3 = 1'b1;
            end
        end
    end
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_SYS_RST);
    sequence ask0;
        I_M_HTRANS[1] && O_M_SLAVE_SEL[2:0] == 3'h3;
    endsequence
    reset_clear_a: assert property (disable iff (1'b0) I_SYS_RST |=> !O_S_CONNECTED)
        else $error("slave connected after reset");
    decode_map_a: assert property (I_M_HADDR[31:28] == 4'h4 |-> O_M_SLAVE_SEL[2:0] == 3'h3)
        else $error("wrong slave decoded");
    remap_own_a: assert property (I_M_HADDR[31:28] == 4'h0 |->
        O_M_SLAVE_SEL[2:0] == (I_REMAP_CONTROL[0] ? 3'h0 : 3'h2)) else $error("remap decode wrong");
    latency_stall_a: assert property (ask0 ##0 !(c3 && own3 == 3'h0) |-> !O_M_HREADY[0])
        else $error("ready without grant");
    grant_bound_a: assert property (ask0 |-> ##[0:40] O_M_HREADY[0])
        else $error("master never served");
    idle_drop_a: assert property ((k3 == 2'h0 && !req3) [*4] |-> !c3)
        else $error("idle slave kept connected");
    fixed_park_a: assert property ((k3 == 2'h2 && id3 == 4'h2 && !req3) [*4] |-> c3 && own3 == 3'h2)
        else $error("idle slave not on fixed master");
    unwired_id_a: assert property ((k3 == 2'h2 && id3 > 4'h5 && !req3) [*4] |-> !c3)
        else $error("unwired fixed id parked");
    last_keep_a: assert property (k3 == 2'h1 && c3 && !req3 ##1 k3 == 2'h1 |-> c3 && $stable(own3))
        else $error("last master lost");
endmodule
bind mbx_matrix_arb mbx_asserts chk_u (.I_CORE_CLK(I_CORE_CLK), .I_SYS_RST(I_SYS_RST),
    .I_M_HADDR(I_M_HADDR), .I_M_HTRANS(I_M_HTRANS), .I_REMAP_CONTROL(I_REMAP_CONTROL),
    .I_SLAVE_CONFIG_DEFKIND(I_SLAVE_CONFIG_DEFKIND), .I_SLAVE_CONFIG_DEFID(I_SLAVE_CONFIG_DEFID),
    .O_M_HREADY(O_M_HREADY), .O_M_SLAVE_SEL(O_M_SLAVE_SEL), .O_S_CONNECTED(O_S_CONNECTED),
    .O_S_MASTER(O_S_MASTER));

// file: bench/mbx_slave_rdy.sv
`timescale 1ns/10ps
module mbx_slave_rdy (
    input wire clk,
    input wire rst,
    input wire slow,
    output logic [4:0] rdy
);
    logic ph_reg;
    // Slow slaves add a wait state every other cycle
    always @(posedge clk) ph_reg <= rst ? 1'b0 : ~ph_reg;
    assign rdy = slow ? {5{ph_reg}} : 5'h1F;
endmodule

// file: bench/tb_multilayer_bus_slave_arbitration.sv
`timescale 1ns/10ps
`include "mbx_consts.vh"
module tb_multilayer_bus_slave_arbitration;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic slow = 1'b0;
    logic [191:0] haddr = '0;
    logic [11:0] htrans = '0;
    logic [5:0] remap = '0;
    logic [9:0] defkind = '0;
    logic [19:0] defid = '0;
    logic [9:0] arbkind = '0;
    logic [59:0] prio = '0;
    logic [17:0] hburst = '0;
    logic [17:0] split = {6{`MBX_SPLIT_4}};
    logic [39:0] slot = {5{`MBX_SLOT_RST}};
    wire [4:0] srdy;
    wire [5:0] mrdy;
    wire [17:0] msel;
    wire [4:0] sconn;
    wire [14:0] sown;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    // ----------------
    // Design and slave model
    // ----------------
    mbx_matrix_arb dut_u (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_M_HADDR(haddr),
        .I_M_HTRANS(htrans), .I_M_HBURST(hburst), .I_REMAP_CONTROL(remap),
        .I_MASTER_CONFIG_SPLIT(split), .I_SLAVE_CONFIG_SLOT(slot),
        .I_SLAVE_CONFIG_DEFKIND(defkind), .I_SLAVE_CONFIG_DEFID(defid),
        .I_SLAVE_CONFIG_ARBKIND(arbkind), .I_SLAVE_PRIORITY(prio), .I_S_HREADY(srdy),
        .O_M_HREADY(mrdy), .O_M_SLAVE_SEL(msel), .O_S_CONNECTED(sconn), .O_S_MASTER(sown));
    mbx_slave_rdy rdy_u (.clk(clk), .rst(rst), .slow(slow), .rdy(srdy));
    // Clock and hang limit
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            $display("FAIL %0t timeout", $time);
            stop_test;
        end
    end
    // ----------------
    // Helpers
    // ----------------
    task chk(input [7:0] got, input [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task put(input [5:0] act, input [31:0] a);
        for (int m = 0; m < 6; m++) begin
            haddr[m*32+:32] = a;
            htrans[m*2+:2] = act[m] ? `MBX_HT_NSEQ : 2'h0;
        end
    endtask
    task idle();
        @(negedge clk);
        put(6'h00, 32'h4000_0000);
        repeat (4) @(negedge clk);
    endtask
    task grant(input [5:0] act, input [2:0] exp);
        int n;
        n = 0;
        put(act, 32'h4000_0000);
        do begin
            @(negedge clk);
            n++;
        end while (!(|(mrdy & act)) && n < 9);
        chk({7'h0, |(mrdy & act)}, 8'h01);
        chk({5'h0, sown[11:9]}, {5'h0, exp});
    endtask
    // Master 0 runs four beats; master 1 joins after the first
    task t_burst(input [2:0] hb, input [2:0] sp, input [7:0] sl, input [7:0] exp);
        int n;
        arbkind[7:6] = `MBX_ARB_RR;
        hburst[2:0] = hb;
        split[2:0] = sp;
        slot[31:24] = sl;
        haddr = {6{32'h4000_0000}};
        for (int b = 0; b < 4; b++) begin
            htrans[1:0] = (b == 0) ? `MBX_HT_NSEQ : `MBX_HT_SEQ;
            htrans[3:2] = (b == 0) ? 2'h0 : `MBX_HT_NSEQ;
            #1;
            for (n = 0; n < 9 && !mrdy[0]; n++) begin
                @(negedge clk);
                #1;
            end
            chk({4'h0, mrdy[0], sown[11:9]}, 8'h08);
            @(negedge clk);
        end
        htrans[1:0] = 2'h0;
        #1;
        chk({5'h0, sown[11:9]}, exp);
        idle();
        hburst[2:0] = `MBX_HB_SINGLE;
        split[2:0] = `MBX_SPLIT_4;
        slot[31:24] = `MBX_SLOT_RST;
    endtask
    task stop_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ----------------
    // Scenarios
    // ----------------
    task t_decode();
        remap = 6'h01;
        put(6'h03, 32'h0000_0000);
        #1;
        chk({5'h0, msel[2:0]}, 8'h00);
        chk({5'h0, msel[5:3]}, 8'h02);
        @(negedge clk);
        remap = 6'h00;
        idle();
    endtask
    task t_nodef();
        put(6'h01, 32'h4000_0000);
        #1;
        chk({7'h0, mrdy[0]}, 8'h00);
        @(negedge clk);
        chk({7'h0, mrdy[0]}, 8'h01);
        idle();
        chk({7'h0, sconn[3]}, 8'h00);
    endtask
    task t_last();
        defkind[7:6] = `MBX_DEF_LAST;
        grant(6'h02, 3'h1);
        idle();
        chk({4'h0, sconn[3], sown[11:9]}, 8'h09);
        put(6'h02, 32'h4000_0000);
        #1;
        chk({7'h0, mrdy[1]}, 8'h01);
        @(negedge clk);
        put(6'h01, 32'h4000_0000);
        #1;
        chk({7'h0, mrdy[0]}, 8'h00);
        idle();
    endtask
    task t_fixed();
        defkind[7:6] = `MBX_DEF_FIXED;
        defid[15:12] = 4'h2;
        idle();
        chk({4'h0, sconn[3], sown[11:9]}, 8'h0A);
        put(6'h04, 32'h4000_0000);
        #1;
        chk({7'h0, mrdy[2]}, 8'h01);
        @(negedge clk);
        defid[15:12] = 4'hF;
        idle();
        chk({7'h0, sconn[3]}, 8'h00);
        defkind[7:6] = `MBX_DEF_NONE;
    endtask
    task t_arb();
        grant(6'h07, 3'h0);
        grant(6'h06, 3'h1);
        idle();
        arbkind[7:6] = `MBX_ARB_PRIO;
        slow = 1'b1;
        grant(6'h07, 3'h2);
        idle();
        prio[37:36] = 2'h3;
        grant(6'h07, 3'h0);
        idle();
        slow = 1'b0;
    endtask
    // Main sequence
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        chk({3'h0, sconn}, 8'h00);
        t_decode();
        t_nodef();
        t_last();
        t_fixed();
        t_arb();
        t_burst(3'h3, `MBX_SPLIT_4, 8'h10, 8'h01);
        t_burst(`MBX_HB_INCR, `MBX_SPLIT_INF, 8'h10, 8'h00);
        t_burst(`MBX_HB_INCR, `MBX_SPLIT_4, 8'h10, 8'h01);
        t_burst(`MBX_HB_INCR, `MBX_SPLIT_INF, 8'h02, 8'h01);
        stop_test();
    end
endmodule
